//--- logic/nibble_reg.v
`timescale 1ns/1ns
`include "port_io_regs.vh"
// ----------------------------------------
// 4-bit control register loaded from the accumulator
// ----------------------------------------
module nibble_reg (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Load
  input wire load_i,
  input wire [`NIB_W-1:0] data_i,
  // Contents
  output reg [`NIB_W-1:0] value_o
);
  always @(posedge clk_i) begin
    if (reset_i) begin
      value_o <= `NIB_RST;
    end else if (load_i) begin
      value_o <= data_i;
    end
  end
endmodule // nibble_reg

//--- logic/port_io_instruction_exec.v
// Overview of operation
// (RULE1) Port read loads accumulator from pins
// (RULE2) Port write drives accumulator onto latch
// (RULE3) Set-all op sets every indexed-port bit
// (RULE4) Bit clear zeroes bit chosen by index
// (RULE5) Bit set raises bit chosen by index
// (RULE6) Bit test skips when bit zero
// (RULE7) Single-bit port clear and set ops
// (RULE8) Pull-up registers read into accumulator
// (RULE9) Accumulator written into pull-up registers
// (RULE10) Wakeup registers read into accumulator
// (RULE11) Accumulator written into wakeup registers
// (RULE12) Accumulator written into drive-type registers
// (RULE13) One cycle per op, carry untouched
// (RULE14) Software keeps bit index in range
`timescale 1ns/1ns
`include "port_io_regs.vh"
module port_io_instruction_exec (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Instruction from the core
  input wire op_valid_i,
  input wire [`OP_W-1:0] op_i,
  input wire [`NIB_W-1:0] acc_i,
  input wire [`IDX_W-1:0] bit_index_i,
  // Port pins (asynchronous levels)
  input wire [`NIB_W-1:0] first_io_port_i,
  input wire [`NIB_W-1:0] second_io_port_i,
  input wire [`NIB_W-1:0] third_io_port_i,
  // Results to the core
  output reg acc_load_o,
  output reg [`NIB_W-1:0] acc_o,
  output reg skip_o,
  // Output latches
  output reg [`NIB_W-1:0] first_io_port_o,
  output reg [`NIB_W-1:0] second_io_port_o,
  output reg [`NIB_W-1:0] third_io_port_o,
  output reg [`DPORT_W-1:0] bit_port_o,
  output reg single_port_o,
  // Control registers
  output wire [`NIB_W-1:0] pullup_ctrl_first_o,
  output wire [`NIB_W-1:0] pullup_ctrl_second_o,
  output wire [`NIB_W-1:0] wakeup_ctrl_first_o,
  output wire [`NIB_W-1:0] wakeup_ctrl_second_o,
  output wire [`NIB_W-1:0] wakeup_ctrl_third_o,
  output wire [`NIB_W-1:0] drive_type_ctrl_first_o,
  output wire [`NIB_W-1:0] drive_type_ctrl_second_o,
  output wire [`NIB_W-1:0] drive_type_ctrl_third_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins pass two flops, so a read sees levels two cycles old.
  reg [`NIB_W-1:0] first_meta_q;
  reg [`NIB_W-1:0] first_sync_q;
  reg [`NIB_W-1:0] second_meta_q;
  reg [`NIB_W-1:0] second_sync_q;
  reg [`NIB_W-1:0] third_meta_q;
  reg [`NIB_W-1:0] third_sync_q;
  always @(posedge clk_i) begin
    if (reset_i) begin
      first_meta_q <= `NIB_RST;
      first_sync_q <= `NIB_RST;
      second_meta_q <= `NIB_RST;
      second_sync_q <= `NIB_RST;
      third_meta_q <= `NIB_RST;
      third_sync_q <= `NIB_RST;
    end else begin
      first_meta_q <= first_io_port_i;
      first_sync_q <= first_meta_q;
      second_meta_q <= second_io_port_i;
      second_sync_q <= second_meta_q;
      third_meta_q <= third_io_port_i;
      third_sync_q <= third_meta_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Idle cycles decode as no op, so every strobe below stays low.
  wire [`OP_W-1:0] op;
  assign op = op_valid_i ? op_i : `OP_NONE;
  wire rd_first;
  wire rd_second;
  wire rd_third;
  wire wr_first;
  wire wr_second;
  wire wr_third;
  wire set_all;
  wire clr_bit;
  wire set_bit;
  wire test_bit;
  wire clr_single;
  wire set_single;
  wire rd_pull_first;
  wire wr_pull_first;
  wire rd_pull_second;
  wire wr_pull_second;
  wire rd_wake_first;
  wire wr_wake_first;
  wire rd_wake_second;
  wire wr_wake_second;
  wire rd_wake_third;
  wire wr_wake_third;
  wire wr_drive_first;
  wire wr_drive_second;
  wire wr_drive_third;
  assign rd_first = (op == `OP_READ_FIRST);
  assign rd_second = (op == `OP_READ_SECOND);
  assign rd_third = (op == `OP_READ_THIRD);
  assign wr_first = (op == `OP_WRITE_FIRST);
  assign wr_second = (op == `OP_WRITE_SECOND);
  assign wr_third = (op == `OP_WRITE_THIRD);
  assign set_all = (op == `SET_ALL_BITS_OP);
  assign clr_bit = (op == `OP_CLR_BIT);
  assign set_bit = (op == `SET_INDEXED_BIT_OP);
  assign test_bit = (op == `TEST_INDEXED_BIT_SKIP_OP);
  assign clr_single = (op == `CLEAR_SINGLE_PORT_OP);
  assign set_single = (op == `SET_SINGLE_PORT_OP);
  assign rd_pull_first = (op == `OP_READ_PULL_FIRST);
  assign wr_pull_first = (op == `OP_WRITE_PULL_FIRST);
  assign rd_pull_second = (op == `OP_READ_PULL_SECOND);
  assign wr_pull_second = (op == `OP_WRITE_PULL_SECOND);
  assign rd_wake_first = (op == `OP_READ_WAKE_FIRST);
  assign wr_wake_first = (op == `OP_WRITE_WAKE_FIRST);
  assign rd_wake_second = (op == `OP_READ_WAKE_SECOND);
  assign wr_wake_second = (op == `OP_WRITE_WAKE_SECOND);
  assign rd_wake_third = (op == `OP_READ_WAKE_THIRD);
  assign wr_wake_third = (op == `OP_WRITE_WAKE_THIRD);
  assign wr_drive_first = (op == `OP_WRITE_DRIVE_FIRST);
  assign wr_drive_second = (op == `OP_WRITE_DRIVE_SECOND);
  assign wr_drive_third = (op == `OP_WRITE_DRIVE_THIRD);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Each loads in the single cycle of its write op; carry is not an
  // input here, so no op can disturb it.
  nibble_reg pull_first_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_pull_first), // RULE9
    .data_i(acc_i),
    .value_o(pullup_ctrl_first_o)
  );

  nibble_reg pull_second_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_pull_second), // RULE9
    .data_i(acc_i),
    .value_o(pullup_ctrl_second_o)
  );

  nibble_reg wake_first_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_wake_first), // RULE11
    .data_i(acc_i),
    .value_o(wakeup_ctrl_first_o)
  );

  nibble_reg wake_second_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_wake_second), // RULE11
    .data_i(acc_i),
    .value_o(wakeup_ctrl_second_o)
  );

  nibble_reg wake_third_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_wake_third), // RULE11
    .data_i(acc_i),
    .value_o(wakeup_ctrl_third_o)
  );

  nibble_reg drive_first_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_drive_first), // RULE12
    .data_i(acc_i),
    .value_o(drive_type_ctrl_first_o)
  );

  nibble_reg drive_second_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_drive_second), // RULE12
    .data_i(acc_i),
    .value_o(drive_type_ctrl_second_o)
  );

  nibble_reg drive_third_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(wr_drive_third), // RULE12
    .data_i(acc_i),
    .value_o(drive_type_ctrl_third_o)
  );

  // ----------------------------------------
  // Accumulator read path and skip
  // ----------------------------------------
  reg [`NIB_W-1:0] rd_data;
  wire rd_hit;
  assign rd_hit = rd_first | rd_second | rd_third | rd_pull_first |
                  rd_pull_second | rd_wake_first | rd_wake_second |
                  rd_wake_third;
  always @* begin
    rd_data = `NIB_RST;
    case (op)
      `OP_READ_FIRST: rd_data = first_sync_q; // RULE1
      `OP_READ_SECOND: rd_data = second_sync_q; // RULE1
      `OP_READ_THIRD: rd_data = third_sync_q; // RULE1
      `OP_READ_PULL_FIRST: rd_data = pullup_ctrl_first_o; // RULE8
      `OP_READ_PULL_SECOND: rd_data = pullup_ctrl_second_o; // RULE8
      `OP_READ_WAKE_FIRST: rd_data = wakeup_ctrl_first_o; // RULE10
      `OP_READ_WAKE_SECOND: rd_data = wakeup_ctrl_second_o; // RULE10
      `OP_READ_WAKE_THIRD: rd_data = wakeup_ctrl_third_o; // RULE10
      default: rd_data = `NIB_RST;
    endcase
  end

  // Outside 0 to 5 the test gives no skip; software keeps the index valid.
  wire test_ok;
  wire skip_d;
  assign test_ok = (bit_index_i <= `TEST_MAX_IDX); // RULE6
  assign skip_d = test_bit && test_ok && !bit_port_o[bit_index_i]; // RULE6

  always @(posedge clk_i) begin
    if (reset_i) begin
      acc_load_o <= 1'b0;
      acc_o <= `NIB_RST;
    end else begin
      acc_load_o <= rd_hit; // RULE13
      acc_o <= rd_data;
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      skip_o <= 1'b0;
    end else begin
      skip_o <= skip_d; // RULE6
    end
  end

  // ----------------------------------------
  // General port latches
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      first_io_port_o <= `NIB_RST;
    end else if (wr_first) begin
      first_io_port_o <= acc_i; // RULE2
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      second_io_port_o <= `NIB_RST;
    end else if (wr_second) begin
      second_io_port_o <= acc_i; // RULE2
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      third_io_port_o <= `NIB_RST;
    end else if (wr_third) begin
      third_io_port_o <= acc_i; // RULE2
    end
  end

  // ----------------------------------------
  // Bit-addressable port latch
  // ----------------------------------------
  // Clear and set act on any index 0 to 7; only the test is limited.
  always @(posedge clk_i) begin
    if (reset_i) begin
      bit_port_o <= `DPORT_RST;
    end else if (set_all) begin
      bit_port_o <= `DPORT_ALL; // RULE3
    end else if (clr_bit) begin
      bit_port_o[bit_index_i] <= 1'b0; // RULE4
    end else if (set_bit) begin
      bit_port_o[bit_index_i] <= 1'b1; // RULE5
    end
  end

  // ----------------------------------------
  // Single-bit port latch
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      single_port_o <= 1'b0;
    end else if (clr_single) begin
      single_port_o <= 1'b0; // RULE7
    end else if (set_single) begin
      single_port_o <= 1'b1; // RULE7
    end
  end
endmodule // port_io_instruction_exec

//--- logic/port_io_regs.vh
`ifndef PORT_IO_REGS_VH
`define PORT_IO_REGS_VH
// ----------------------------------------
// Operation codes on op_i
// ----------------------------------------
`define OP_W 5
`define OP_NONE 5'h00
`define OP_READ_FIRST 5'h01
`define OP_READ_SECOND 5'h02
`define OP_READ_THIRD 5'h03
`define OP_WRITE_FIRST 5'h04
`define OP_WRITE_SECOND 5'h05
`define OP_WRITE_THIRD 5'h06
`define SET_ALL_BITS_OP 5'h07
`define OP_CLR_BIT 5'h08
`define SET_INDEXED_BIT_OP 5'h09
`define TEST_INDEXED_BIT_SKIP_OP 5'h0A
`define CLEAR_SINGLE_PORT_OP 5'h0B
`define SET_SINGLE_PORT_OP 5'h0C
`define OP_READ_PULL_FIRST 5'h0D
`define OP_WRITE_PULL_FIRST 5'h0E
`define OP_READ_PULL_SECOND 5'h0F
`define OP_WRITE_PULL_SECOND 5'h10
`define OP_READ_WAKE_FIRST 5'h11
`define OP_WRITE_WAKE_FIRST 5'h12
`define OP_READ_WAKE_SECOND 5'h13
`define OP_WRITE_WAKE_SECOND 5'h14
`define OP_READ_WAKE_THIRD 5'h15
`define OP_WRITE_WAKE_THIRD 5'h16
`define OP_WRITE_DRIVE_FIRST 5'h17
`define OP_WRITE_DRIVE_SECOND 5'h18
`define OP_WRITE_DRIVE_THIRD 5'h19
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define NIB_W 4
`define DPORT_W 8
`define IDX_W 3
`define TEST_MAX_IDX 3'h5
`define NIB_RST 4'h0
`define DPORT_RST 8'h00
`define DPORT_ALL 8'hFF
`endif

//--- testbench/pin_model.sv
`timescale 1ns/1ns
// ------
// Pins of the three ports
// ------
module pin_model (
  // Clock and levels asked for
  input wire clk_i,
  input wire [11:0] level_i,
  // Pin levels
  output reg [11:0] pin_o
);
  // Pins move with the clock, unrelated to op timing
  always @(posedge clk_i) begin
    pin_o <= level_i;
  end
endmodule // pin_model

//--- testbench/port_io_sva.sv
`timescale 1ns/1ns
`include "port_io_regs.vh"
// ------
// Port op checks
// ------
module port_io_sva (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Instruction
  input wire op_valid_i,
  input wire [4:0] op_i,
  input wire [3:0] acc_i,
  input wire [2:0] bit_index_i,
  // Results
  input wire acc_load_o,
  input wire [3:0] acc_o,
  input wire skip_o,
  input wire [3:0] first_io_port_o,
  input wire [7:0] bit_port_o,
  input wire single_port_o,
  input wire [3:0] pullup_ctrl_second_o
);
  // Idle cycles look like op code zero
  wire [4:0] op = op_valid_i ? op_i : `OP_NONE;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_port_write: assert property (op == `OP_WRITE_FIRST |=>
    first_io_port_o == $past(acc_i)) else $error("port write");
  a_set_all: assert property (op == `SET_ALL_BITS_OP |=>
    bit_port_o == 8'hFF) else $error("set all");
  a_bit_clear: assert property (op == `OP_CLR_BIT |=>
    bit_port_o == ($past(bit_port_o) & ~(8'h01 << $past(bit_index_i))))
    else $error("bit clear");
  a_bit_set: assert property (op == `SET_INDEXED_BIT_OP |=>
    bit_port_o == ($past(bit_port_o) | (8'h01 << $past(bit_index_i))))
    else $error("bit set");
  a_test_skip: assert property (op == `TEST_INDEXED_BIT_SKIP_OP |=>
    skip_o == ($past(bit_index_i) <= 3'h5 &&
    !$past(bit_port_o[bit_index_i]))) else $error("bit test");
  a_single_set: assert property (op == `SET_SINGLE_PORT_OP |=>
    single_port_o) else $error("single set");
  a_pullup_read: assert property (op == `OP_READ_PULL_SECOND |=>
    acc_load_o && acc_o == $past(pullup_ctrl_second_o)) else $error("rd");
  a_pullup_write: assert property (op == `OP_WRITE_PULL_SECOND |=>
    pullup_ctrl_second_o == $past(acc_i)) else $error("pullup write");
  a_idle_quiet: assert property (op == `OP_NONE |=>
    !acc_load_o && !skip_o) else $error("idle");
  c_skip: cover property (skip_o);
  c_load: cover property (acc_load_o);
  c_set: cover property (op == `SET_INDEXED_BIT_OP);
endmodule // port_io_sva

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`include "port_io_regs.vh"
// ------
// Bench
// ------
module tb_top;
  reg clk_i = 0, reset_i = 1, op_valid_i = 0, sk = 0;
  reg [4:0] op_i = 0, c = 0;
  reg [3:0] acc_i = 0;
  reg [2:0] bit_index_i = 0, y = 0;
  reg [11:0] lv = 0;
  reg [15:0] lfsr = 16'h3D1C;
  reg [8:0] st = 0;
  integer error_cnt = 0, compares = 0, i;
  wire [11:0] pin, prt;
  wire [31:0] ctl;
  wire [7:0] bit_port_o;
  wire [3:0] acc_o;
  wire acc_load_o, skip_o, single_port_o;
  always #5 clk_i = ~clk_i;
  pin_model pin_u (.clk_i, .level_i(lv), .pin_o(pin));
  port_io_instruction_exec dut_u (.clk_i, .reset_i, .op_valid_i, .op_i,
    .acc_i, .bit_index_i, .first_io_port_i(pin[3:0]), .acc_load_o, .acc_o,
    .second_io_port_i(pin[7:4]), .third_io_port_i(pin[11:8]), .skip_o,
    .first_io_port_o(prt[3:0]), .second_io_port_o(prt[7:4]), .bit_port_o,
    .third_io_port_o(prt[11:8]), .single_port_o,
    .pullup_ctrl_first_o(ctl[3:0]), .pullup_ctrl_second_o(ctl[7:4]),
    .wakeup_ctrl_first_o(ctl[11:8]), .wakeup_ctrl_second_o(ctl[15:12]),
    .wakeup_ctrl_third_o(ctl[19:16]), .drive_type_ctrl_first_o(ctl[23:20]),
    .drive_type_ctrl_second_o(ctl[27:24]),
    .drive_type_ctrl_third_o(ctl[31:28]));
  function [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [8:0] model(input [8:0] s, input [4:0] k, input [2:0] b);
    begin
      model = s;
      if (k == `SET_ALL_BITS_OP) model[7:0] = 8'hFF;
      if (k == `OP_CLR_BIT || k == `SET_INDEXED_BIT_OP)
        model[b] = k == `SET_INDEXED_BIT_OP;
      if (k == `CLEAR_SINGLE_PORT_OP || k == `SET_SINGLE_PORT_OP)
        model[8] = k == `SET_SINGLE_PORT_OP;
    end
  endfunction
  task chk(input string n, input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %s exp %h seen %h", n, exp, seen);
      end
    end
  endtask
  // Valid stays up between calls, so ops run back to back
  task op(input [4:0] k, input [3:0] a, input [2:0] b);
    begin
      op_valid_i = 1;
      op_i = k;
      acc_i = a;
      bit_index_i = b;
      @(negedge clk_i);
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge clk_i);
    reset_i = 0;
    @(negedge clk_i);
    for (i = 0; i < 3; i = i + 1) begin
      lfsr = nxt(lfsr);
      lv = lfsr[11:0];
      op(`OP_WRITE_FIRST + i, lfsr[15:12], 3'h0);
      chk("pout", prt[i*4+:4], lfsr[15:12]);
      repeat (4) op(`OP_NONE, 4'h0, 3'h0);
      op(`OP_READ_FIRST + i, 4'h0, 3'h0);
      chk("pin", {acc_load_o, acc_o}, {1'b1, lv[i*4+:4]});
    end
    $display("port test done");
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = nxt(lfsr);
      c = i < 5 ? `OP_WRITE_PULL_FIRST + 2 * i
                : `OP_WRITE_DRIVE_FIRST + i - 5;
      op(c, lfsr[3:0], 3'h0);
      chk("ctl", ctl[i*4+:4], lfsr[3:0]);
      if (i < 5) op(c - 5'h01, 4'h0, 3'h0);
      if (i < 5) chk("rd", acc_o, lfsr[3:0]);
    end
    $display("register test done");
    for (i = 0; i < 80; i = i + 1) begin
      lfsr = nxt(lfsr);
      y = lfsr[5:3];
      c = lfsr[2:0] < 6 ? `SET_ALL_BITS_OP + lfsr[2:0] : 5'h1F;
      sk = c == `TEST_INDEXED_BIT_SKIP_OP && y <= 3'h5 && !st[y];
      op(c, lfsr[9:6], y);
      st = model(st, c, y);
      chk("bits", bit_port_o, st[7:0]);
      chk("cbit", single_port_o, st[8]);
      chk("skip", skip_o, sk);
      chk("load", acc_load_o, 8'h00);
    end
    $display("bit test done");
    stop_test;
  end
endmodule // tb_top
bind port_io_instruction_exec port_io_sva chk_u (.clk_i, .reset_i,
  .op_valid_i, .op_i, .acc_i, .bit_index_i, .acc_load_o, .acc_o, .skip_o,
  .first_io_port_o, .bit_port_o, .single_port_o, .pullup_ctrl_second_o);
